//--- rtl/bit_rate_defines.svh
`ifndef BIT_RATE_DEFINES_SVH
`define BIT_RATE_DEFINES_SVH

// Register index of the bit-rate configuration word (byte address = index * 4)
`define BRC_CONFIG_IDX 4'h0
`define BRC_CONFIG_ADDR 6'h00
// Field positions
`define BRC_SRC_SEL_HI 25
`define BRC_SRC_SEL_LO 24
`define BRC_TX_DIV_HI 20
`define BRC_TX_DIV_LO 19
`define BRC_RX_DIV_HI 17
`define BRC_RX_DIV_LO 16
`define BRC_TX_INT_SEL 14
`define BRC_RX_INT_SEL 12
`define BRC_DIVISOR_HI 10
`define BRC_DIVISOR_LO 0
// Legacy rate-mode bit position (own location)
`define BRC_LEGACY_MODE 31
// Writable bit mask and reset value
`define BRC_WRITE_MASK 32'h831B_57FF
`define BRC_RESET 32'h0000_0000
// Crystal predivider ratio
`define BRC_XTAL_DIV 3'h5
`define BRC_XTAL_DIV_LAST 3'h4

`endif

//--- rtl/bit_rate_pkg.sv
package bit_rate_pkg;
  typedef enum logic [1:0] {
    SRC_CRYSTAL,
    SRC_SYSTEM,
    SRC_EXT_A,
    SRC_EXT_B
  } gen_source_t;
endpackage : bit_rate_pkg

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for an asynchronous level
module pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Level in and out
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  logic sync_q;

  // First stage read only by the second
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : pin_sync
`default_nettype wire

//--- rtl/rate_divider.sv
`timescale 1ns/1ns
`default_nettype none
// Counts enable ticks 0..divisor, toggles output at terminal count
module rate_divider (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Source tick and divisor
  input wire logic i_tick,
  input wire logic [10:0] i_divisor,
  // Divided square wave and its edge pulse
  output logic o_clk,
  output logic o_toggle
);
  logic [10:0] count_q;
  logic [10:0] count_d;
  logic out_q;
  logic out_d;
  logic toggle_d;

  // Terminal count toggles, giving /(2*(N+1))
  always_comb begin
    count_d = count_q;
    out_d = out_q;
    toggle_d = 1'b0;
    if (i_tick) begin
      if (count_q >= i_divisor) begin
        count_d = 11'h000;
        out_d = ~out_q;
        toggle_d = 1'b1;
      end else begin
        count_d = count_q + 11'h001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= 11'h000;
      out_q <= 1'b0;
      o_toggle <= 1'b0;
    end else begin
      count_q <= count_d;
      out_q <= out_d;
      o_toggle <= toggle_d;
    end
  end

  assign o_clk = out_q;
endmodule : rate_divider
`default_nettype wire

//--- rtl/serial_bit_rate_clock_select.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "bit_rate_defines.svh"

// Notes on behaviour
// [R1] Bits 17:16 hold a read/write receive divide-rate field, reset zero, setting rx oversampling.
// [R2] Bit 14 picks the generator output for the transmitter when 0 and the recovered clock when 1.
// [R3] Bit 12 picks the generator output for the receiver when 0 and the recovered clock when 1.
// [R4] The transmitter takes an internal clock only while its clock origin field is zero.
// [R5] The receiver takes an internal clock only while its clock origin field is zero.
// [R6] The generator divides its selected source by two times the 11-bit divisor plus one.
// [R7] Source select 00 crystal-derived, 01 system, 10 external input a, 11 external input b.
// [R8] Software sets the divisor so generator rate is baud times oversampling factor.
// [R9] External inputs must not exceed a quarter of the system clock.
// [R10] The crystal-derived clock is the crystal divided by five.
// [R11] With the system clock as source, software keeps the baud at or below system clock over 32.
// [R12] Software sets the legacy mode bit whenever a divide-rate field is non-zero.
// [R13] The divider counts source ticks 0..divisor and toggles its output at each terminal count.
module serial_bit_rate_clock_select (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Clock sources (asynchronous pins)
  input wire logic i_crystal_clk,
  input wire logic i_ext_clock_in_a,
  input wire logic i_ext_clock_in_b,
  // Recovered clock from the pll, same domain
  input wire logic i_recovered_clock_pll,
  // Clock origin fields of the channel
  input wire logic [1:0] i_tx_clock_origin,
  input wire logic [1:0] i_rx_clock_origin,
  // Generated clocks, internal flags and rate-mode fields
  output logic o_bit_rate_clk,
  output logic o_tx_clk,
  output logic o_rx_clk,
  output logic o_tx_internal,
  output logic o_rx_internal,
  output logic [1:0] o_tx_divide_rate,
  output logic [1:0] o_rx_divide_rate,
  output logic o_legacy_rate_mode
);
  logic [31:0] config_q;
  logic [31:0] config_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic hit;
  logic xtal_s;
  logic ext_a_s;
  logic ext_b_s;
  logic xtal_last_q;
  logic ext_a_last_q;
  logic ext_b_last_q;
  logic [2:0] xtal_cnt_q;
  logic [2:0] xtal_cnt_d;
  logic crystal_div_clock_tick;
  logic src_tick;
  logic gen_clk;
  logic [10:0] rate_divisor;
  bit_rate_pkg::gen_source_t generator_source_sel;
  logic tx_internal_clk_sel;
  logic rx_internal_clk_sel;
  logic tx_clk_d;
  logic rx_clk_d;
  logic tx_int_d;
  logic rx_int_d;

  // Field extraction
  assign rate_divisor = config_q[`BRC_DIVISOR_HI:`BRC_DIVISOR_LO];
  assign generator_source_sel = bit_rate_pkg::gen_source_t'(config_q[`BRC_SRC_SEL_HI:`BRC_SRC_SEL_LO]);
  assign tx_internal_clk_sel = config_q[`BRC_TX_INT_SEL];
  assign rx_internal_clk_sel = config_q[`BRC_RX_INT_SEL];
  assign hit = (i_addr == `BRC_CONFIG_ADDR);

  // Register write and read data; unmapped reads return zero
  always_comb begin
    config_d = config_q;
    rdata_d = 32'h0000_0000;
    if (i_wr && hit) begin
      config_d = i_wdata & `BRC_WRITE_MASK; // see [R1]
    end
    if (i_rd && hit) begin
      rdata_d = config_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      config_q <= `BRC_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      config_q <= config_d;
      rdata_q <= rdata_d;
    end
  end

  // Source pins sampled into the system domain
  pin_sync u_sync_xtal (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_crystal_clk),
    .o_sync(xtal_s)
  );
  pin_sync u_sync_a (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_ext_clock_in_a),
    .o_sync(ext_a_s)
  );
  pin_sync u_sync_b (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_ext_clock_in_b),
    .o_sync(ext_b_s)
  );

  // Rising edges of sources; sampling caps them at half of system clock
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      xtal_last_q <= 1'b0;
      ext_a_last_q <= 1'b0;
      ext_b_last_q <= 1'b0;
      xtal_cnt_q <= 3'h0;
    end else begin
      xtal_last_q <= xtal_s;
      ext_a_last_q <= ext_a_s;
      ext_b_last_q <= ext_b_s; // see [R9]
      xtal_cnt_q <= xtal_cnt_d;
    end
  end

  // Crystal predivider: one tick every five crystal edges
  always_comb begin
    xtal_cnt_d = xtal_cnt_q;
    crystal_div_clock_tick = 1'b0;
    if (xtal_s && !xtal_last_q) begin
      if (xtal_cnt_q == `BRC_XTAL_DIV_LAST) begin
        xtal_cnt_d = 3'h0;
        crystal_div_clock_tick = 1'b1; // see [R10]
      end else begin
        xtal_cnt_d = xtal_cnt_q + 3'h1;
      end
    end
  end

  // Generator source mux
  always_comb begin
    case (generator_source_sel)
      bit_rate_pkg::SRC_CRYSTAL: src_tick = crystal_div_clock_tick; // see [R7]
      bit_rate_pkg::SRC_SYSTEM: src_tick = 1'b1;
      bit_rate_pkg::SRC_EXT_A: src_tick = ext_a_s && !ext_a_last_q;
      bit_rate_pkg::SRC_EXT_B: src_tick = ext_b_s && !ext_b_last_q;
      default: src_tick = 1'b0;
    endcase
  end

  // Divider by 2*(N+1)
  rate_divider u_div (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(src_tick),
    .i_divisor(rate_divisor), // see [R6] see [R13]
    .o_clk(gen_clk),
    .o_toggle()
  );

  // Tx and rx clock selection; external origins leave internal clock idle
  always_comb begin
    tx_int_d = (i_tx_clock_origin == 2'h0); // see [R4]
    rx_int_d = (i_rx_clock_origin == 2'h0); // see [R5]
    tx_clk_d = 1'b0;
    rx_clk_d = 1'b0;
    if (tx_int_d) begin
      tx_clk_d = tx_internal_clk_sel ? i_recovered_clock_pll : gen_clk; // see [R2]
    end
    if (rx_int_d) begin
      rx_clk_d = rx_internal_clk_sel ? i_recovered_clock_pll : gen_clk; // see [R3]
    end
  end

  // Registered outputs; one cycle of latency on every clock path
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bit_rate_clk <= 1'b0;
      o_tx_clk <= 1'b0;
      o_rx_clk <= 1'b0;
      o_tx_internal <= 1'b0;
      o_rx_internal <= 1'b0;
      o_tx_divide_rate <= 2'h0;
      o_rx_divide_rate <= 2'h0;
      o_legacy_rate_mode <= 1'b0;
    end else begin
      o_bit_rate_clk <= gen_clk;
      o_tx_clk <= tx_clk_d;
      o_rx_clk <= rx_clk_d;
      o_tx_internal <= tx_int_d;
      o_rx_internal <= rx_int_d;
      o_tx_divide_rate <= config_q[`BRC_TX_DIV_HI:`BRC_TX_DIV_LO];
      o_rx_divide_rate <= config_q[`BRC_RX_DIV_HI:`BRC_RX_DIV_LO]; // see [R1]
      o_legacy_rate_mode <= config_q[`BRC_LEGACY_MODE];
    end
  end

  assign o_rdata = rdata_q;
endmodule : serial_bit_rate_clock_select
`default_nettype wire

//--- verif/clock_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side clock pins, stepped on the falling edge so the sync delay is fixed
module clock_pins_model (
  input wire logic i_clk,
  output logic o_crystal,
  output logic o_ext_a,
  output logic o_ext_b
);
  int cnt = 0;
  // Periods of 3, 4 and 6 system cycles
  always @(negedge i_clk) begin
    cnt <= cnt + 1;
    o_crystal <= (cnt % 3) == 0;
    o_ext_a <= (cnt % 4) < 2;
    o_ext_b <= (cnt % 6) < 3;
  end
endmodule : clock_pins_model
`default_nettype wire

//--- verif/bit_rate_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "bit_rate_defines.svh"
module bit_rate_sva (
  // Clock, reset, register port
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Clock selection
  input wire logic i_recovered_clock_pll,
  input wire logic [1:0] i_tx_clock_origin,
  input wire logic [1:0] i_rx_clock_origin,
  input wire logic o_bit_rate_clk,
  input wire logic o_tx_clk,
  input wire logic o_tx_internal,
  input wire logic o_rx_internal,
  input wire logic [1:0] o_tx_divide_rate,
  input wire logic [1:0] o_rx_divide_rate,
  input wire logic o_legacy_rate_mode
);
  logic [31:0] cfg_q, cfg_d;
  logic [11:0] gap_q, gap_d;
  logic [3:0] quiet_q, quiet_d;
  logic armed_q, armed_d, bclk_q, flip;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Shadow word; period is only judged once writes have been quiet a while
  always_comb begin
    flip = o_bit_rate_clk ^ bclk_q;
    cfg_d = (i_wr && i_addr == 6'h00) ? (i_wdata & `BRC_WRITE_MASK) : cfg_q;
    gap_d = flip ? 12'h000 : gap_q + 12'h001;
    quiet_d = i_wr ? 4'h0 : ((quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1);
    armed_d = i_wr ? 1'b0 : ((flip && quiet_q == 4'hf) ? 1'b1 : armed_q);
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_q <= 32'h0000_0000;
      gap_q <= 12'h000;
      quiet_q <= 4'h0;
      armed_q <= 1'b0;
      bclk_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      gap_q <= gap_d;
      quiet_q <= quiet_d;
      armed_q <= armed_d;
      bclk_q <= o_bit_rate_clk;
    end
  end
  a_read_back_word: assert property (i_rd && i_addr == 6'h00 |=> o_rdata == $past(cfg_q))
    else $error("read word wrong");
  a_rdata_idle_zero: assert property (!i_rd || i_addr != 6'h00 |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero");
  a_fields_copied: assert property ((!i_wr)[*3] |-> o_rx_divide_rate == cfg_q[17:16]
    && o_tx_divide_rate == cfg_q[20:19] && o_legacy_rate_mode == cfg_q[31]) else $error("field copy wrong");
  // Release edge itself still resets the flags, so only start once reset was seen high
  a_tx_internal_flag: assert property (i_reset_n |=> o_tx_internal == ($past(i_tx_clock_origin) == 2'b00))
    else $error("tx internal flag wrong");
  a_rx_internal_flag: assert property (i_reset_n |=> o_rx_internal == ($past(i_rx_clock_origin) == 2'b00))
    else $error("rx internal flag wrong");
  a_tx_off_external: assert property (i_tx_clock_origin != 2'b00 |=> !o_tx_clk)
    else $error("tx clock not off");
  a_tx_pll_pick: assert property ((i_tx_clock_origin == 2'b00 && cfg_q[14] && i_recovered_clock_pll)[*3]
    |-> o_tx_clk) else $error("tx pll clock not taken");
  a_gen_half_period: assert property (flip && armed_q && cfg_q[25:24] == 2'b01
    |-> gap_q == {1'b0, cfg_q[10:0]}) else $error("generator period wrong");
  c_system_toggle: cover property (flip && armed_q && cfg_q[25:24] == 2'b01);
  c_tx_pll: cover property (i_tx_clock_origin == 2'b00 && cfg_q[14] && o_tx_clk);
  c_unmapped_read: cover property (i_rd && i_addr != 6'h00);
endmodule : bit_rate_sva
bind serial_bit_rate_clock_select bit_rate_sva u_sva (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_recovered_clock_pll, .i_tx_clock_origin, .i_rx_clock_origin, .o_bit_rate_clk, .o_tx_clk,
  .o_tx_internal, .o_rx_internal, .o_tx_divide_rate, .o_rx_divide_rate, .o_legacy_rate_mode);
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "bit_rate_defines.svh"
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pll = 1'b0;
  logic [1:0] tx_org = 2'b00;
  logic [1:0] rx_org = 2'b00;
  logic [31:0] rdata, w;
  logic [31:0] seed = 32'h0000_500a;
  logic xtal, ext_a, ext_b, bclk, txc, rxc, txi, rxi, lm;
  logic [1:0] tdr, rdr;
  int miscompares = 0;
  int num_checks = 0;
  int p;
  // 25 MHz system clock
  always #20 clk = ~clk;
  clock_pins_model pins (.i_clk(clk), .o_crystal(xtal), .o_ext_a(ext_a), .o_ext_b(ext_b));
  serial_bit_rate_clock_select dut (.i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_crystal_clk(xtal), .i_ext_clock_in_a(ext_a),
    .i_ext_clock_in_b(ext_b), .i_recovered_clock_pll(pll), .i_tx_clock_origin(tx_org),
    .i_rx_clock_origin(rx_org), .o_bit_rate_clk(bclk), .o_tx_clk(txc), .o_rx_clk(rxc), .o_tx_internal(txi),
    .o_rx_internal(rxi), .o_tx_divide_rate(tdr), .o_rx_divide_rate(rdr), .o_legacy_rate_mode(lm));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Generator period in system cycles; crystal pins run at 3 cycles, externals at 4 and 6
  function automatic int gen_period(input int src, input int n);
    int f[4] = '{15, 1, 4, 6};
    return 2 * (n + 1) * f[src];
  endfunction : gen_period
  // Selected clock while the generator output is high
  function automatic logic [31:0] pick(input logic sel, input logic [1:0] org);
    return {31'h0, (org == 2'b00) && (sel ? pll : 1'b1)};
  endfunction : pick
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr32
  task automatic rd32(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, exp);
  endtask : rd32
  // Edges of the generator line up with the system clock, so time maps to whole cycles
  task automatic period(output int c);
    time t0;
    repeat (3) @(posedge bclk);
    t0 = $time;
    @(posedge bclk);
    c = int'(($time - t0) / 40);
  endtask : period
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd32(6'h00, 32'h0000_0000);
    // Random words come back through the write mask; software rules kept on them
    repeat (8) begin
      w = xs();
      w[31] = w[31] | (|{w[20:19], w[17:16]});
      // System source needs a divisor of at least 16 to stay under the baud ceiling in any mode
      if (w[25:24] == 2'b01) begin
        w[4] = 1'b1;
      end
      wr32(6'h00, w);
      rd32(6'h00, w & `BRC_WRITE_MASK);
      chk("modes", {27'h0, lm, tdr, rdr}, {27'h0, w[31], w[20:19], w[17:16]});
    end
    wr32(6'h04, 32'hffff_ffff);
    rd32(6'h04, 32'h0000_0000);
    rd32(6'h00, w & `BRC_WRITE_MASK);
    // System source in default 16x mode, divisor 0: fastest legal baud
    wr32(6'h00, 32'h0100_0000);
    period(p);
    chk("period", p, gen_period(1, 0));
    for (int s = 0; s < 4; s++) begin
      wr32(6'h00, {6'h00, s[1:0], 13'h0000, s[10:0]});
      period(p);
      chk("period", p, gen_period(s, s));
    end
    // Every origin against both internal sources and both recovered clock levels
    for (int m = 0; m < 16; m++) begin
      wr32(6'h00, {6'h00, 2'b01, 9'h000, m[0], 1'b0, m[0], 1'b0, 11'd7});
      tx_org <= m[2:1];
      rx_org <= m[2:1] ^ 2'b11;
      pll <= m[3];
      // Long enough for the checker to judge a full generator half period
      repeat (3) @(posedge bclk);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("tx_int", {31'h0, txi}, {31'h0, tx_org == 2'b00});
      chk("rx_int", {31'h0, rxi}, {31'h0, rx_org == 2'b00});
      chk("tx_clk", {31'h0, txc}, pick(m[0], tx_org));
      chk("rx_clk", {31'h0, rxc}, pick(m[0], rx_org));
    end
    results();
  end
  // Whole run needs well under a tenth of this span
  initial begin
    #4_000_000;
    miscompares++;
    results();
  end
endmodule : tb_top
`default_nettype wire
